// [hw/prp_rx_map.vh]
// Constants for the packet receive port: sizes, word fields, addresses, status threshold
`ifndef PRP_RX_MAP_VH
`define PRP_RX_MAP_VH

// Number of ports served and width of a port index
`define PRP_NPORT 4
`define PRP_PW 2
// Per-port FIFO depth in words and pointer width
`define PRP_DEPTH 16
`define PRP_AW 4
// Stored word: 16 data bits plus four markers
`define PRP_WW 20
`define PRP_F_SOP 16
`define PRP_F_EOP 17
`define PRP_F_MOD 18
`define PRP_F_ERR 19
// Null port address and default base address of this device
`define PRP_NULL_ADDR 5'h1f
`define PRP_BASE_ADDR 5'h00
// Fill level in words that raises packet-available without a packet end
`define PRP_PA_THRESH 5'h08

`endif

// [hw/prp_rx_port.v]
// Multi-port packet receive port facing a link-layer reader, with per-port FIFOs
`timescale 1ns/10ps
`include "prp_rx_map.vh"
// Summary of operation
// (R01) On the final word, word-size flag high means one byte, low means two.
// (R02) Every word is full except the last; word-size only meaningful on last word.
// (R03) Read enable deasserted: start, end, size and error outputs are released.
// (R04) Null or foreign address selected while deasserted keeps outputs released.
// (R05) Start marker accompanies the first word of every packet; the code drops it on a one-word packet, where it falls with the end marker.
// (R06) End marker on the final word, never together with the start marker.
// (R07) Error flag marks an aborted packet, only on its final word.
// (R08) Error may come from overflow, abort, missing start or end, or parity.
// (R09) Error flag counts only while data valid is high.
// (R10) Packet mode: deasserted cycles select a port, asserted cycles transfer.
// (R11) Packet mode: while asserted, the address polls packet-available status.
// (R12) Byte mode: each asserted cycle moves one word from the addressed port.
// (R13) Byte mode: no polling; each port has its own direct status output.
// (R14) The reader drains FIFOs fast enough and may pause in any cycle.
// (R15) The reader drives a five-bit address selecting the port read.
// (R16) Packet mode: the address also picks the port whose status is polled.
// (R17) Address 1Fh is never answered, with data or with status.
// (R18) Data valid drops on empty or packet end and stays low until deselect; the code does this in packet mode only.
// (R19) Packet available when the FIFO holds a packet end or threshold words.
// (R20) Data is valid only with read enable asserted and a valid port selected.
// (R21) Outputs change and inputs are taken on the link clock rising edge; direct status and the byte-mode poll drop follow the system clock.
module prp_rx_port (
    input wire clk_sys,
    input wire srst,
    input wire rfclk,
    input wire renb_n,
    input wire [4:0] radr,
    input wire byte_mode,
    input wire usr_valid,
    input wire [`PRP_PW-1:0] usr_port,
    input wire [15:0] usr_data,
    input wire usr_sop,
    input wire usr_eop,
    input wire usr_mod,
    input wire usr_err,
    output reg usr_ready_ff,
    output reg [15:0] rx_data_ff,
    output reg rx_sop_ff,
    output reg rx_eop_ff,
    output reg rx_mod_ff,
    output reg rx_err_ff,
    output reg rx_val_ff,
    output reg rx_oe_ff,
    output reg poll_pa_ff,
    output reg poll_pa_oe_ff,
    output reg [`PRP_NPORT-1:0] direct_pa_ff
);
    localparam NP = `PRP_NPORT;
    localparam PW = `PRP_PW;
    localparam AW = `PRP_AW;
    localparam WW = `PRP_WW;

    // Link pin synchronisers; two stages each, and a third on the link clock for edge detection
    reg rfclk_s1_ff, rfclk_s2_ff, rfclk_s3_ff;
    reg renb_s1_ff, renb_s2_ff;
    reg [4:0] radr_s1_ff, radr_s2_ff;
    reg mode_s1_ff, mode_s2_ff;
    always @(posedge clk_sys) begin
        if (srst) begin
            // Link clock idles high, so leaving reset shows no false edge
            rfclk_s1_ff <= 1'b1;
            rfclk_s2_ff <= 1'b1;
            rfclk_s3_ff <= 1'b1;
            renb_s1_ff <= 1'b1;
            renb_s2_ff <= 1'b1;
            radr_s1_ff <= `PRP_NULL_ADDR;
            radr_s2_ff <= `PRP_NULL_ADDR;
            mode_s1_ff <= 1'b0;
            mode_s2_ff <= 1'b0;
        end else begin
            rfclk_s1_ff <= rfclk;
            rfclk_s2_ff <= rfclk_s1_ff;
            rfclk_s3_ff <= rfclk_s2_ff;
            renb_s1_ff <= renb_n;
            renb_s2_ff <= renb_s1_ff;
            radr_s1_ff <= radr;
            radr_s2_ff <= radr_s1_ff;
            mode_s1_ff <= byte_mode;
            mode_s2_ff <= mode_s1_ff;
        end
    end

    wire lk_rise = rfclk_s2_ff & ~rfclk_s3_ff;
    wire lk_fall = ~rfclk_s2_ff & rfclk_s3_ff;

    // Inputs are held mid-period so the rising edge sees what the reader drove for it
    reg hold_renb_ff;
    reg [4:0] hold_adr_ff;
    always @(posedge clk_sys) begin
        if (srst) begin
            hold_renb_ff <= 1'b1;
            hold_adr_ff <= `PRP_NULL_ADDR;
        end else if (lk_fall) begin // [R21]
            hold_renb_ff <= renb_s2_ff;
            hold_adr_ff <= radr_s2_ff;
        end
    end

    // Two-entry buffer between the user stream and the port FIFOs
    reg [WW+PW-1:0] bf_mem [0:1];
    reg bf_wp_ff, bf_rp_ff;
    reg [1:0] bf_cnt_ff;
    wire [WW+PW-1:0] bf_head = bf_mem[bf_rp_ff];
    wire [PW-1:0] bf_port = bf_head[WW+PW-1:WW];
    wire [NP-1:0] f_full;
    wire bf_push = usr_valid & usr_ready_ff;
    wire bf_pop = (bf_cnt_ff != 2'd0) & ~f_full[bf_port];
    reg [1:0] nxt_bf_cnt;
    always @* begin
        nxt_bf_cnt = bf_cnt_ff;
        if (bf_push & ~bf_pop)
            nxt_bf_cnt = bf_cnt_ff + 2'd1;
        else if (bf_pop & ~bf_push)
            nxt_bf_cnt = bf_cnt_ff - 2'd1;
    end
    always @(posedge clk_sys) begin
        if (bf_push)
            bf_mem[bf_wp_ff] <= {usr_port, usr_err, usr_mod, usr_eop, usr_sop, usr_data}; // [R08]
    end
    always @(posedge clk_sys) begin
        if (srst) begin
            bf_wp_ff <= 1'b0;
            bf_rp_ff <= 1'b0;
            bf_cnt_ff <= 2'd0;
            usr_ready_ff <= 1'b0;
        end else begin
            if (bf_push)
                bf_wp_ff <= ~bf_wp_ff;
            if (bf_pop)
                bf_rp_ff <= ~bf_rp_ff;
            bf_cnt_ff <= nxt_bf_cnt;
            usr_ready_ff <= (nxt_bf_cnt != 2'd2);
        end
    end

    // Read-side decisions made on each link rising edge
    wire [4:0] adr_off = hold_adr_ff - `PRP_BASE_ADDR;
    wire adr_hit = (hold_adr_ff != `PRP_NULL_ADDR) && (adr_off < NP); // [R17]
    reg [PW-1:0] sel_ff;
    reg sel_ok_ff;
    reg stop_ff;
    wire [NP-1:0] f_empty;
    wire [NP-1:0] f_pa;
    wire [NP*AW-1:0] rp_vec;
    wire [NP*AW-1:0] wp_vec;
    reg [PW-1:0] rd_port;
    reg rd_go;
    always @* begin
        rd_port = sel_ff;
        rd_go = 1'b0;
        if (lk_rise && !hold_renb_ff) begin
            if (mode_s2_ff) begin
                rd_port = adr_off[PW-1:0]; // [R12]
                rd_go = adr_hit & ~f_empty[adr_off[PW-1:0]];
            end else begin
                rd_go = sel_ok_ff & ~stop_ff & ~f_empty[sel_ff]; // [R10] [R20]
            end
        end
    end

    // Port FIFO storage, one region per port
    reg [WW-1:0] f_mem [0:NP*`PRP_DEPTH-1];
    wire [WW-1:0] f_head = f_mem[{rd_port, rp_vec[rd_port*AW +: AW]}];
    always @(posedge clk_sys) begin
        if (bf_pop)
            f_mem[{bf_port, wp_vec[bf_port*AW +: AW]}] <= bf_head[WW-1:0];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_port
            reg [AW:0] wp_ff, rp_ff;
            reg [4:0] eopc_ff;
            wire wr = bf_pop && (bf_port == gi);
            wire rd = rd_go && (rd_port == gi);
            wire [AW:0] lvl = wp_ff - rp_ff;
            wire wr_eop = wr & bf_head[`PRP_F_EOP];
            wire rd_eop = rd & f_head[`PRP_F_EOP];
            assign f_empty[gi] = (lvl == {(AW+1){1'b0}});
            assign f_full[gi] = lvl[AW];
            assign wp_vec[gi*AW +: AW] = wp_ff[AW-1:0];
            assign rp_vec[gi*AW +: AW] = rp_ff[AW-1:0];
            assign f_pa[gi] = (eopc_ff != 5'd0) || (lvl >= `PRP_PA_THRESH); // [R19]
            always @(posedge clk_sys) begin
                if (srst) begin
                    wp_ff <= {(AW+1){1'b0}};
                    rp_ff <= {(AW+1){1'b0}};
                    eopc_ff <= 5'd0;
                end else begin
                    if (wr)
                        wp_ff <= wp_ff + 1'b1;
                    if (rd)
                        rp_ff <= rp_ff + 1'b1;
                    if (wr_eop & ~rd_eop)
                        eopc_ff <= eopc_ff + 5'd1;
                    else if (rd_eop & ~wr_eop)
                        eopc_ff <= eopc_ff - 5'd1;
                end
            end
        end
    endgenerate

    // Next values of the link-facing registers; they move only on a link rising edge, except the poll drive, which byte mode drops at once
    wire h_eop = f_head[`PRP_F_EOP];
    reg [PW-1:0] nxt_sel;
    reg nxt_sel_ok;
    reg nxt_stop;
    reg [15:0] nxt_rx_data;
    reg nxt_rx_sop;
    reg nxt_rx_eop;
    reg nxt_rx_mod;
    reg nxt_rx_err;
    reg nxt_rx_val;
    reg nxt_rx_oe;
    reg nxt_poll_pa;
    reg nxt_poll_pa_oe;
    always @* begin
        nxt_sel = sel_ff;
        nxt_sel_ok = sel_ok_ff;
        nxt_stop = stop_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_sop = rx_sop_ff;
        nxt_rx_eop = rx_eop_ff;
        nxt_rx_mod = rx_mod_ff;
        nxt_rx_err = rx_err_ff;
        nxt_rx_val = rx_val_ff;
        nxt_rx_oe = rx_oe_ff;
        nxt_poll_pa = poll_pa_ff;
        // A switch to byte mode drops the poll drive without waiting for the link clock
        nxt_poll_pa_oe = poll_pa_oe_ff & ~mode_s2_ff; // [R13]
        if (lk_rise) begin
            if (hold_renb_ff) begin
                // Selection phase: everything released
                nxt_rx_oe = 1'b0; // [R03]
                nxt_rx_val = 1'b0;
                nxt_poll_pa_oe = 1'b0;
                nxt_sel = adr_off[PW-1:0]; // [R15]
                nxt_sel_ok = adr_hit; // [R04] [R17]
                nxt_stop = 1'b0;
            end else begin
                nxt_rx_oe = mode_s2_ff ? adr_hit : sel_ok_ff; // [R04] [R20]
                nxt_poll_pa_oe = ~mode_s2_ff & adr_hit; // [R11] [R17]
                nxt_poll_pa = f_pa[adr_off[PW-1:0]]; // [R16]
                nxt_rx_val = rd_go; // [R09] [R18]
                // Markers are cleared on empty cycles so a stale end marker never lingers
                nxt_rx_sop = 1'b0;
                nxt_rx_eop = 1'b0;
                nxt_rx_mod = 1'b0;
                nxt_rx_err = 1'b0;
                if (rd_go) begin
                    nxt_rx_data = f_head[15:0]; // [R02]
                    nxt_rx_sop = f_head[`PRP_F_SOP] & ~h_eop; // [R05] [R06]
                    nxt_rx_eop = h_eop; // [R06]
                    nxt_rx_mod = f_head[`PRP_F_MOD] & h_eop; // [R01]
                    nxt_rx_err = f_head[`PRP_F_ERR] & h_eop; // [R07]
                end
                // Held low until the reader deselects the port
                if (!mode_s2_ff && (!rd_go || h_eop))
                    nxt_stop = 1'b1; // [R18]
            end
        end
    end

    // Link-facing output registers
    always @(posedge clk_sys) begin
        if (srst) begin
            sel_ff <= {PW{1'b0}};
            sel_ok_ff <= 1'b0;
            stop_ff <= 1'b0;
            rx_data_ff <= 16'h0000;
            rx_sop_ff <= 1'b0;
            rx_eop_ff <= 1'b0;
            rx_mod_ff <= 1'b0;
            rx_err_ff <= 1'b0;
            rx_val_ff <= 1'b0;
            rx_oe_ff <= 1'b0;
            poll_pa_ff <= 1'b0;
            poll_pa_oe_ff <= 1'b0;
            direct_pa_ff <= {NP{1'b0}};
        end else begin
            sel_ff <= nxt_sel;
            sel_ok_ff <= nxt_sel_ok;
            stop_ff <= nxt_stop;
            rx_data_ff <= nxt_rx_data;
            rx_sop_ff <= nxt_rx_sop;
            rx_eop_ff <= nxt_rx_eop;
            rx_mod_ff <= nxt_rx_mod;
            rx_err_ff <= nxt_rx_err;
            rx_val_ff <= nxt_rx_val;
            rx_oe_ff <= nxt_rx_oe;
            poll_pa_ff <= nxt_poll_pa;
            poll_pa_oe_ff <= nxt_poll_pa_oe;
            // Direct status follows the FIFOs every cycle, in both modes
            direct_pa_ff <= f_pa; // [R13]
        end
    end
endmodule // prp_rx_port

// [hw/unused_placeholder_none.v]
// Empty design unit kept deliberately absent of logic
`timescale 1ns/10ps

// [verif/prp_link_reader.sv]
// Link-side reader model: link clock, read enable and port address
`timescale 1ns/10ps
module prp_link_reader (
    output reg rfclk,
    output reg renb_n,
    output reg [4:0] radr
);
    initial begin
        rfclk = 1'b1;
        renb_n = 1'b1;
        radr = 5'h1f;
    end
    // One link cycle; clock stands high between calls, returns once outputs settle
    task cyc(input en_n, input [4:0] adr);
        begin
            renb_n = en_n;
            radr = adr;
            #31 rfclk = 1'b0;
            #62.5 rfclk = 1'b1;
            #31.5;
        end
    endtask
endmodule // prp_link_reader

// [verif/prp_rx_checker.sv]
// Concurrent checks on the receive port link outputs
`timescale 1ns/10ps
module prp_rx_checker (
    input wire clk_sys,
    input wire srst,
    input wire rfclk,
    input wire renb_n,
    input wire [4:0] radr,
    input wire byte_mode,
    input wire rx_sop_ff,
    input wire rx_eop_ff,
    input wire rx_mod_ff,
    input wire rx_err_ff,
    input wire rx_val_ff,
    input wire rx_oe_ff,
    input wire poll_pa_oe_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Link clock rise with read enable and address held across it
    sequence s_rise(en_n, hit);
        (renb_n == en_n) && hit && !rfclk ##1 (renb_n == en_n) && hit && rfclk;
    endsequence
    // Set once valid drops in a packet-mode transfer; cleared when the port is released
    reg val_q_ff;
    reg stop_seen_ff;
    always @(posedge clk_sys) begin
        if (srst) begin
            val_q_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
        end else begin
            val_q_ff <= rx_val_ff;
            if (!rx_oe_ff || byte_mode)
                stop_seen_ff <= 1'b0;
            else if (val_q_ff && !rx_val_ff)
                stop_seen_ff <= 1'b1;
        end
    end
    a_val_needs_oe: assert property (rx_val_ff |-> rx_oe_ff)
        else $error("valid while released");
    a_sop_not_eop: assert property (rx_val_ff && rx_eop_ff |-> !rx_sop_ff)
        else $error("start with end");
    a_mod_last_only: assert property (rx_val_ff && !rx_eop_ff |-> !rx_mod_ff)
        else $error("size flag on inner word");
    a_err_last_only: assert property (rx_val_ff && rx_err_ff |-> rx_eop_ff)
        else $error("error before last word");
    a_byte_no_poll: assert property (byte_mode [*8] |-> !poll_pa_oe_ff)
        else $error("poll driven in byte mode");
    a_desel_release: assert property (s_rise(1'b1, 1'b1) |-> ##8 !rx_oe_ff && !rx_val_ff && !poll_pa_oe_ff)
        else $error("outputs driven while deselected");
    a_null_no_poll: assert property (s_rise(1'b0, radr == 5'h1f) |-> ##8 !poll_pa_oe_ff)
        else $error("null address polled");
    a_poll_on_hit: assert property (s_rise(1'b0, radr < 5'h04 && !byte_mode) |-> ##8 poll_pa_oe_ff)
        else $error("own address not polled");
    a_val_stop_hold: assert property (stop_seen_ff |-> !rx_val_ff)
        else $error("valid back before deselect");
endmodule // prp_rx_checker
bind prp_rx_port prp_rx_checker chk_u (.clk_sys, .srst, .rfclk, .renb_n, .radr, .byte_mode,
    .rx_sop_ff, .rx_eop_ff, .rx_mod_ff, .rx_err_ff, .rx_val_ff, .rx_oe_ff, .poll_pa_oe_ff);

// [verif/test_prp_rx_port.sv]
// Self-checking bench for the packet receive port
`timescale 1ns/10ps
`include "prp_rx_map.vh"
module test_prp_rx_port;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg byte_mode = 1'b0;
    reg usr_valid = 1'b0;
    reg [1:0] usr_port = 2'h0;
    reg [15:0] usr_data = 16'h0000;
    reg [3:0] usr_mk = 4'h0;
    reg [15:0] w;
    wire rfclk, renb_n, usr_ready_ff, rx_sop_ff, rx_eop_ff, rx_mod_ff, rx_err_ff;
    wire rx_val_ff, rx_oe_ff, poll_pa_ff, poll_pa_oe_ff;
    wire [4:0] radr;
    wire [15:0] rx_data_ff;
    wire [3:0] direct_pa_ff;
    wire [21:0] rx_vec = {rx_oe_ff, rx_val_ff, rx_sop_ff, rx_eop_ff, rx_mod_ff, rx_err_ff, rx_data_ff};
    integer n_fail = 0;
    integer tests_run = 0;
    integer i;
    always #2.5 clk_sys = ~clk_sys;
    prp_link_reader lnk_u (.rfclk(rfclk), .renb_n(renb_n), .radr(radr));
    prp_rx_port dut_u (.clk_sys(clk_sys), .srst(srst), .rfclk(rfclk), .renb_n(renb_n),
        .radr(radr), .byte_mode(byte_mode), .usr_valid(usr_valid), .usr_port(usr_port),
        .usr_data(usr_data), .usr_sop(usr_mk[0]), .usr_eop(usr_mk[1]), .usr_mod(usr_mk[2]),
        .usr_err(usr_mk[3]), .usr_ready_ff(usr_ready_ff), .rx_data_ff(rx_data_ff),
        .rx_sop_ff(rx_sop_ff), .rx_eop_ff(rx_eop_ff), .rx_mod_ff(rx_mod_ff),
        .rx_err_ff(rx_err_ff), .rx_val_ff(rx_val_ff), .rx_oe_ff(rx_oe_ff),
        .poll_pa_ff(poll_pa_ff), .poll_pa_oe_ff(poll_pa_oe_ff), .direct_pa_ff(direct_pa_ff));
    task tally_and_finish;
        begin
            if (n_fail == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Offer one word, held until the buffer takes it
    task push(input [1:0] p, input [15:0] d, input [3:0] mk);
        integer k;
        begin
            @(negedge clk_sys);
            usr_valid = 1'b1;
            usr_port = p;
            usr_data = d;
            usr_mk = mk;
            for (k = 0; k < 300 && usr_ready_ff !== 1'b1; k = k + 1)
                @(negedge clk_sys);
            if (k == 300) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t ready timeout", $time);
                tally_and_finish;
            end
            @(posedge clk_sys);
        end
    endtask
    task idle;
        begin
            @(negedge clk_sys);
            usr_valid = 1'b0;
            repeat (8) @(negedge clk_sys);
        end
    endtask
    task sc_packet;
        begin
            push(2'h2, 16'hc3a5, 4'h2);
            push(2'h1, 16'h1111, 4'h1);
            push(2'h1, 16'h2222, 4'h0);
            push(2'h1, 16'h3300, 4'he);
            push(2'h1, 16'h4444, 4'h3);
            idle;
            chk(direct_pa_ff, 4'h6);
            lnk_u.cyc(1'b1, 5'h01);
            chk(rx_vec[21:20], 2'b00);
            lnk_u.cyc(1'b0, 5'h02);
            chk(rx_vec, {6'b111000, 16'h1111});
            chk({poll_pa_oe_ff, poll_pa_ff}, 2'b11);
            lnk_u.cyc(1'b0, 5'h00);
            chk(rx_vec, {6'b110000, 16'h2222});
            chk({poll_pa_oe_ff, poll_pa_ff}, 2'b10);
            lnk_u.cyc(1'b0, 5'h1f);
            chk(rx_vec, {6'b110111, 16'h3300});
            chk(poll_pa_oe_ff, 1'b0);
            lnk_u.cyc(1'b0, 5'h01);
            chk(rx_vec[21:20], 2'b10);
            lnk_u.cyc(1'b1, 5'h01);
            chk(rx_vec[21:20], 2'b00);
            lnk_u.cyc(1'b0, 5'h01);
            chk(rx_vec, {6'b110100, 16'h4444});
            chk(direct_pa_ff, 4'h4);
        end
    endtask
    task sc_null;
        integer j;
        begin
            for (j = 0; j < 2; j = j + 1) begin
                lnk_u.cyc(1'b1, j ? 5'h09 : 5'h1f);
                lnk_u.cyc(1'b0, j ? 5'h09 : 5'h1f);
                chk({rx_oe_ff, poll_pa_oe_ff}, 2'b00);
            end
            lnk_u.cyc(1'b1, 5'h1f);
        end
    endtask
    task sc_byte;
        begin
            @(negedge clk_sys);
            byte_mode = 1'b1;
            repeat (8) @(negedge clk_sys);
            lnk_u.cyc(1'b1, 5'h02);
            chk(rx_val_ff, 1'b0);
            lnk_u.cyc(1'b0, 5'h02);
            chk(rx_vec, {6'b110100, 16'hc3a5});
            chk(poll_pa_oe_ff, 1'b0);
            lnk_u.cyc(1'b0, 5'h02);
            chk(rx_val_ff, 1'b0);
            chk(direct_pa_ff, 4'h0);
        end
    endtask
    // Fill port 3 until refused, then drain it in order
    task sc_fill;
        begin
            for (i = 0; i < 18; i = i + 1)
                push(2'h3, 16'h0100 + i[15:0], {i == 1, i == 1, 1'b0, i == 0});
            idle;
            chk(usr_ready_ff, 1'b0);
            chk(direct_pa_ff, 4'h8);
            for (i = 0; i < 18; i = i + 1) begin
                w = 16'h0100 + i[15:0];
                lnk_u.cyc(1'b0, 5'h03);
                chk({rx_val_ff, rx_sop_ff, rx_mod_ff, rx_err_ff, rx_data_ff}, {1'b1, i == 0, 2'b00, w});
            end
            lnk_u.cyc(1'b0, 5'h03);
            chk({rx_val_ff, usr_ready_ff, direct_pa_ff}, 6'b010000);
        end
    endtask
    // Reset in mid-run with a stored packet: everything returns to its reset value
    task sc_reset;
        begin
            push(2'h0, 16'h5a5a, 4'h3);
            idle;
            chk(direct_pa_ff, 4'h1);
            srst = 1'b1;
            repeat (4) @(negedge clk_sys);
            chk({usr_ready_ff, direct_pa_ff, poll_pa_ff, poll_pa_oe_ff, rx_vec}, 29'h0);
            srst = 1'b0;
            repeat (4) @(negedge clk_sys);
            chk({usr_ready_ff, direct_pa_ff}, 5'h10);
        end
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        repeat (4) @(negedge clk_sys);
        lnk_u.cyc(1'b1, 5'h1f);
        lnk_u.cyc(1'b1, 5'h1f);
        sc_packet;
        sc_null;
        sc_byte;
        sc_fill;
        sc_reset;
        tally_and_finish;
    end
endmodule // test_prp_rx_port
